// ---- common/qfg_pkg.sv ----
/*
  Package for the quad framer global register bank: offsets, field
  positions, key values, id layout, highway modes and carrier structs.
  Assumes an 8-bit host data bus with a byte address.
*/
package qfg_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_MAKER_ID_LOW = 8'h00;
  localparam logic [7:0] ADDR_MAKER_ID_HIGH_PART_LOW = 8'h01;
  localparam logic [7:0] ADDR_PART_NUMBER_MID = 8'h02;
  localparam logic [7:0] ADDR_PART_HIGH_REVISION = 8'h03;
  localparam logic [7:0] ADDR_SCRATCH_NOTEBOOK = 8'h04;
  localparam logic [7:0] ADDR_SOFTWARE_RESET_KEY = 8'h05;
  localparam logic [7:0] ADDR_GLOBAL_CONFIG = 8'h06;

  // ----------------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------------
  localparam logic [7:0] SOFT_RESET_KEY = 8'h91;
  localparam logic [7:0] SOFT_RESET_ACTIVE_READ = 8'h01;
  localparam logic [7:0] SOFT_RESET_IDLE_READ = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] SCRATCH_RESET = 8'h00;
  localparam int NUM_FRAMERS = 4;

  // Identification, arbitrary neutral values
  localparam logic [11:0] MAKER_ID_VALUE = 12'h0a5;
  localparam logic [15:0] PART_NUMBER_VALUE = 16'h1234;
  localparam logic [3:0] REVISION_VALUE = 4'h1;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    HWY_PLAIN_2M,
    HWY_PLAIN_8M,
    HWY_PLAIN_16M,
    HWY_VENDOR_2M,
    HWY_VENDOR_8M,
    HWY_PCM_16M,
    HWY_INVALID
  } qfg_highway_t;

  // Field layout of the global configuration byte, bit 7 down to bit 0
  typedef struct packed {
    logic global_irq_mask;
    logic rise_enable;
    logic fall_enable;
    logic irq_polarity_invert;
    logic perf_monitor_enable;
    logic highway_vendor_mode;
    logic highway_16m_select;
    logic alarm_hier_enable;
  } qfg_config_t;

  // Host bus request
  typedef struct packed {
    logic cs;
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } qfg_bus_req_t;

endpackage : qfg_pkg

// ---- rtl/qfg_global_regs.sv ----
/*
  Global register bank of a four-channel framer: id, scratch, software
  reset key and global configuration, plus the interrupt pin, latched
  event edge select and one-second shadow strobe.
  Assumes a synchronous 8-bit host bus on clock; read data is registered.
*/
`timescale 1ns/1ps

module qfg_global_regs
  import qfg_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Host bus
  input wire qfg_bus_req_t bus_req,
  input wire logic bus_style_active_low,
  output logic [7:0] rdata,
  // Strap and pulse pins
  input wire logic highway_strap_pin,
  input wire logic one_second_pulse_in,
  // Per-framer status and control
  input wire logic [NUM_FRAMERS-1:0] status_level,
  input wire logic [NUM_FRAMERS-1:0] event_mask,
  input wire logic [NUM_FRAMERS-1:0] event_clear,
  input wire logic [NUM_FRAMERS-1:0] framer_soft_reset,
  output logic [NUM_FRAMERS-1:0] event_latched,
  output logic [NUM_FRAMERS-1:0] framer_reset_active,
  // Global outputs
  output logic irq_pin,
  output logic shadow_update,
  output logic soft_reset_active,
  output qfg_config_t config_out,
  output qfg_highway_t highway_mode
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [7:0] scratch_reg;
  logic soft_reset_reg;
  qfg_config_t config_reg;
  logic [NUM_FRAMERS-1:0] status_prev_reg;
  logic [NUM_FRAMERS-1:0] event_reg;
  logic pulse_sync;
  logic pulse_prev_reg;
  logic shadow_reg;
  logic [7:0] rdata_next;
  logic wr_en;
  logic rd_en;
  logic irq_active;
  logic [NUM_FRAMERS-1:0] edge_hit;

  assign wr_en = bus_req.cs & bus_req.wr;
  assign rd_en = bus_req.cs & bus_req.rd;

  // ----------------------------------------------------------------------
  // Scratch byte
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      scratch_reg <= SCRATCH_RESET;
    end else if (wr_en && bus_req.addr == ADDR_SCRATCH_NOTEBOOK) begin
      scratch_reg <= bus_req.wdata;
    end
  end

  // ----------------------------------------------------------------------
  // Software reset key
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      soft_reset_reg <= 1'b0;
    end else if (wr_en && bus_req.addr == ADDR_SOFTWARE_RESET_KEY) begin
      soft_reset_reg <= (bus_req.wdata == SOFT_RESET_KEY);
    end
  end

  assign soft_reset_active = soft_reset_reg;

  // ----------------------------------------------------------------------
  // Global configuration; untouched by software reset
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      config_reg <= CONFIG_RESET;
    end else if (wr_en && bus_req.addr == ADDR_GLOBAL_CONFIG) begin
      config_reg <= bus_req.wdata;
    end
  end

  assign config_out = config_reg;

  // Per-framer reset combines global and local control
  assign framer_reset_active = framer_soft_reset |
    {NUM_FRAMERS{soft_reset_reg}};

  // ----------------------------------------------------------------------
  // Latched status events
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_FRAMERS; gi++) begin : g_evt
      // Edge choice per framer from the two select bits
      assign edge_hit[gi] =
        (config_reg.rise_enable & status_level[gi] &
         ~status_prev_reg[gi]) |
        (config_reg.fall_enable & ~status_level[gi] &
         status_prev_reg[gi]);

      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          status_prev_reg[gi] <= 1'b0;
          event_reg[gi] <= 1'b0;
        end else if (framer_reset_active[gi]) begin
          // Latched state cleared, edge memory follows the input
          status_prev_reg[gi] <= status_level[gi];
          event_reg[gi] <= 1'b0;
        end else begin
          status_prev_reg[gi] <= status_level[gi];
          // Set wins over a clear in the same cycle
          if (edge_hit[gi]) begin
            event_reg[gi] <= 1'b1;
          end else if (event_clear[gi]) begin
            event_reg[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  assign event_latched = event_reg;

  // ----------------------------------------------------------------------
  // Interrupt pin
  // ----------------------------------------------------------------------
  assign irq_active = ~config_reg.global_irq_mask &
    (|(event_reg & ~event_mask));

  // Native level: high for style 0, low for style 1; bit 4 flips it
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irq_pin <= 1'b0;
    end else begin
      irq_pin <= irq_active ^ bus_style_active_low ^
        config_reg.irq_polarity_invert;
    end
  end

  // ----------------------------------------------------------------------
  // One-second shadow strobe
  // ----------------------------------------------------------------------
  qfg_sync u_pulse_sync (
    .clock(clock),
    .rstn(rstn),
    .async_in(one_second_pulse_in),
    .sync_out(pulse_sync)
  );

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pulse_prev_reg <= 1'b0;
    end else begin
      pulse_prev_reg <= pulse_sync;
    end
  end

  // Held off during software reset so shadows stay cleared
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      shadow_reg <= 1'b0;
    end else begin
      shadow_reg <= config_reg.perf_monitor_enable & ~soft_reset_reg &
        pulse_sync & ~pulse_prev_reg;
    end
  end

  assign shadow_update = shadow_reg;

  // ----------------------------------------------------------------------
  // Highway mode decode
  // ----------------------------------------------------------------------
  always_comb begin
    case ({highway_strap_pin, config_reg.highway_vendor_mode,
           config_reg.highway_16m_select})
      3'b000: highway_mode = HWY_PLAIN_2M;
      3'b010: highway_mode = HWY_PLAIN_8M;
      3'b001: highway_mode = HWY_PLAIN_16M;
      3'b100: highway_mode = HWY_VENDOR_2M;
      3'b110: highway_mode = HWY_VENDOR_8M;
      3'b101: highway_mode = HWY_PCM_16M;
      default: highway_mode = HWY_INVALID;
    endcase
  end

  // ----------------------------------------------------------------------
  // Read mux, registered
  // ----------------------------------------------------------------------
  always_comb begin
    case (bus_req.addr)
      ADDR_MAKER_ID_LOW:
        rdata_next = MAKER_ID_VALUE[7:0];
      ADDR_MAKER_ID_HIGH_PART_LOW:
        rdata_next = {PART_NUMBER_VALUE[3:0],
                      MAKER_ID_VALUE[11:8]};
      ADDR_PART_NUMBER_MID:
        rdata_next = PART_NUMBER_VALUE[11:4];
      ADDR_PART_HIGH_REVISION:
        rdata_next = {REVISION_VALUE,
                      PART_NUMBER_VALUE[15:12]};
      ADDR_SCRATCH_NOTEBOOK:
        rdata_next = scratch_reg;
      ADDR_SOFTWARE_RESET_KEY:
        rdata_next = soft_reset_reg ? SOFT_RESET_ACTIVE_READ :
                     SOFT_RESET_IDLE_READ;
      ADDR_GLOBAL_CONFIG:
        rdata_next = config_reg;
      default:
        rdata_next = BYTE_ZERO;
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata <= BYTE_ZERO;
    end else if (rd_en) begin
      rdata <= rdata_next;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  chk_key_enters_reset: assert property (
    @(posedge clock) disable iff (!rstn)
    (wr_en && bus_req.addr == ADDR_SOFTWARE_RESET_KEY &&
     bus_req.wdata == SOFT_RESET_KEY) |=> soft_reset_active)
    else $error("Key write did not enter software reset");

  chk_other_releases: assert property (
    @(posedge clock) disable iff (!rstn)
    (wr_en && bus_req.addr == ADDR_SOFTWARE_RESET_KEY &&
     bus_req.wdata != SOFT_RESET_KEY) |=> !soft_reset_active)
    else $error("Non-key write did not release software reset");

  chk_reset_readback: assert property (
    @(posedge clock) disable iff (!rstn)
    (rd_en && bus_req.addr == ADDR_SOFTWARE_RESET_KEY) |=>
      (rdata == {7'h00, $past(soft_reset_active)}))
    else $error("Reset register read value wrong");

  // Host leaves one idle cycle between requests
  chk_scratch_holds: assert property (
    @(posedge clock) disable iff (!rstn)
    (wr_en && bus_req.addr == ADDR_SCRATCH_NOTEBOOK) ##1 !wr_en ##1
      (rd_en && bus_req.addr == ADDR_SCRATCH_NOTEBOOK &&
       !(wr_en)) |=> (rdata == $past(bus_req.wdata, 3)))
    else $error("Scratch readback mismatch");

  chk_mask_holds_irq: assert property (
    @(posedge clock) disable iff (!rstn)
    config_reg.global_irq_mask |=>
      (irq_pin == ($past(bus_style_active_low) ^
                   $past(config_reg.irq_polarity_invert))))
    else $error("Interrupt not held inactive while masked");

  chk_event_fires_irq: assert property (
    @(posedge clock) disable iff (!rstn)
    (!config_reg.global_irq_mask && |(event_reg & ~event_mask)) |=>
      (irq_pin != ($past(bus_style_active_low) ^
                   $past(config_reg.irq_polarity_invert))))
    else $error("Unmasked event did not assert interrupt");

  chk_set_beats_clear: assert property (
    @(posedge clock) disable iff (!rstn)
    (edge_hit[0] && event_clear[0] && !framer_reset_active[0]) |=>
      event_latched[0])
    else $error("Clear in same cycle overrode a new event");

  chk_rise_latch: assert property (
    @(posedge clock) disable iff (!rstn)
    (config_reg.rise_enable && status_level[0] && !status_prev_reg[0]
     && !framer_reset_active[0]) |=> event_latched[0])
    else $error("Rising edge not latched");

  chk_no_edge_none: assert property (
    @(posedge clock) disable iff (!rstn)
    (!config_reg.rise_enable && !config_reg.fall_enable &&
     !event_latched[0]) |=> !event_latched[0])
    else $error("Event latched with both edge selects clear");

  chk_shadow_gate: assert property (
    @(posedge clock) disable iff (!rstn)
    shadow_update |-> $past(config_reg.perf_monitor_enable))
    else $error("Shadow update while monitoring disabled");

endmodule : qfg_global_regs

// ---- rtl/qfg_sync.sv ----
/*
  Three flip-flop input synchroniser with agreement filter.
  Assumes the input is asynchronous to clock.
*/
`timescale 1ns/1ps
module qfg_sync (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Data
  input wire logic async_in,
  output logic sync_out
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // ----------------------------------------------------------------------
  // Chain; first stage feeds only the second
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Change taken only when stages two and three agree
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sync_out <= 1'b0;
    end else if (s2_reg == s3_reg) begin
      sync_out <= s3_reg;
    end
  end

endmodule : qfg_sync

// ---- verif/qfg_host_model.sv ----
/*
  Host processor model that drives the byte-wide register bus.
  Assumes requests are taken on the rising clock edge, read data one
  cycle later; callers run tasks from one process only.
*/
`timescale 1ns/1ps
module qfg_host_model
  import qfg_pkg::*;
(
  // Clock and read data
  input wire logic clock,
  input wire logic [7:0] rdata,
  // Request
  output qfg_bus_req_t bus_req
);
  // ----------------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------------
  initial begin
    bus_req = '0;
  end

  // Released address and data show the inverse, never a stale copy
  task automatic drive(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
    @(posedge clock);
    #1;
    bus_req = '{cs: 1'b1, wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clock);
    #1;
    bus_req = '{cs: 1'b0, wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : drive

  task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
    if (a == ADDR_GLOBAL_CONFIG && d[2:1] == 2'b11) begin
      d[1] = 1'b0;
    end
    drive(1'b1, a, d);
  endtask : write_byte

  task automatic read_byte(input logic [7:0] a, output logic [7:0] d);
    drive(1'b0, a, 8'h00);
    d = rdata;
  endtask : read_byte

  // Power-up wait shortened: simulation time only
  task automatic power_up_reset();
    write_byte(ADDR_SOFTWARE_RESET_KEY, SOFT_RESET_KEY);
    write_byte(ADDR_SOFTWARE_RESET_KEY, BYTE_ZERO);
  endtask : power_up_reset
endmodule : qfg_host_model

// ---- verif/test_quad_framer_global_regs.sv ----
/*
  Self-checking bench for the global register bank with a host model.
  Assumes the host model and design share one 200 MHz clock.
*/
`timescale 1ns/1ps
module test_quad_framer_global_regs;
  import qfg_pkg::*;
  logic clock, rstn, style, strap, pulse, irq, shadow, sra;
  logic [3:0] status, emask, eclr, fsr, ev_lat, fra, p;
  logic [7:0] rdata, rd, cfg;
  qfg_bus_req_t bus_req;
  qfg_config_t cfg_out;
  qfg_highway_t hwy;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  int n;

  // ----------------------------------------------------------------------
  // Instances
  // ----------------------------------------------------------------------
  qfg_host_model host_u (.clock(clock), .rdata(rdata), .bus_req(bus_req));
  qfg_global_regs dut_u (.clock(clock), .rstn(rstn), .bus_req(bus_req),
    .bus_style_active_low(style), .rdata(rdata), .highway_strap_pin(strap),
    .one_second_pulse_in(pulse), .status_level(status), .event_mask(emask),
    .event_clear(eclr), .framer_soft_reset(fsr), .event_latched(ev_lat),
    .framer_reset_active(fra), .irq_pin(irq), .shadow_update(shadow),
    .soft_reset_active(sra), .config_out(cfg_out), .highway_mode(hwy));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [7:0] id_byte(input int i);
    case (i)
      0: return MAKER_ID_VALUE[7:0];
      1: return {PART_NUMBER_VALUE[3:0], MAKER_ID_VALUE[11:8]};
      2: return PART_NUMBER_VALUE[11:4];
      default: return {REVISION_VALUE, PART_NUMBER_VALUE[15:12]};
    endcase
  endfunction : id_byte

  function automatic qfg_highway_t hwy_exp(input logic [2:0] sc);
    case (sc)
      3'b000: return HWY_PLAIN_2M;
      3'b010: return HWY_PLAIN_8M;
      3'b001: return HWY_PLAIN_16M;
      3'b100: return HWY_VENDOR_2M;
      3'b110: return HWY_VENDOR_8M;
      3'b101: return HWY_PCM_16M;
      default: return HWY_INVALID;
    endcase
  endfunction : hwy_exp

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic step(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask : step

  task automatic final_report();
    $display("checks=%0d miscompares=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Whole run needs well under 2000 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      final_report();
    end
  end

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    rstn = 1'b0; style = 1'b0; strap = 1'b0; pulse = 1'b0;
    status = 4'h0; emask = 4'h0; eclr = 4'h0; fsr = 4'h0;
    n = $urandom(7);
    step(4);
    rstn = 1'b1;
    check(sra, 1'b0);
    for (int a = 0; a < 8; a++) begin
      host_u.read_byte(8'(a), rd);
      check(rd, a < 4 ? id_byte(a) : BYTE_ZERO);
    end
    host_u.power_up_reset();
    $display("test reset_values done");
    // Read-only id ignores writes, scratch keeps random bytes
    for (int i = 0; i < 4; i++) begin
      host_u.write_byte(8'(i), 8'($urandom));
      host_u.read_byte(8'(i), rd);
      check(rd, id_byte(i));
      cfg = 8'($urandom);
      host_u.write_byte(ADDR_SCRATCH_NOTEBOOK, cfg);
      host_u.read_byte(ADDR_SCRATCH_NOTEBOOK, rd);
      check(rd, cfg);
      check(cfg_out, CONFIG_RESET);
    end
    $display("test id_scratch done");
    // Soft reset keeps control, clears latched events
    cfg = 8'($urandom) | 8'h60;
    cfg[2] = 1'b0;
    host_u.write_byte(ADDR_GLOBAL_CONFIG, cfg);
    status = 4'hf;
    step(3);
    check(ev_lat, 4'hf);
    fsr = 4'($urandom);
    step(1);
    check(fra, fsr);
    check(ev_lat, 4'(~fsr));
    host_u.write_byte(ADDR_SOFTWARE_RESET_KEY, SOFT_RESET_KEY);
    check(sra, 1'b1);
    check(fra, 4'hf);
    step(1);
    check(ev_lat, 4'h0);
    check(cfg_out, cfg);
    host_u.read_byte(ADDR_SOFTWARE_RESET_KEY, rd);
    check(rd, SOFT_RESET_ACTIVE_READ);
    rd = 8'($urandom);
    rd[0] = (rd == SOFT_RESET_KEY) ? 1'b0 : rd[0];
    host_u.write_byte(ADDR_SOFTWARE_RESET_KEY, rd);
    check(sra, 1'b0);
    check(fra, fsr);
    host_u.read_byte(ADDR_SOFTWARE_RESET_KEY, rd);
    check(rd, SOFT_RESET_IDLE_READ);
    fsr = 4'h0;
    $display("test soft_reset done");
    // Each edge-select code against a falling then a rising change
    for (int s = 0; s < 4; s++) begin
      host_u.write_byte(ADDR_GLOBAL_CONFIG, {1'b0, 2'(s), 5'h00});
      for (int e = 0; e < 2; e++) begin
        eclr = 4'hf;
        step(2);
        eclr = 4'h0;
        status = ~status;
        step(3);
        check(ev_lat, {4{status[0] ? s[1] : s[0]}});
        check(irq, status[0] ? s[1] : s[0]);
      end
    end
    $display("test edge_select done");
    // Mask, per-event mask, polarity and bus style
    host_u.write_byte(ADDR_GLOBAL_CONFIG, 8'h60);
    // New edges and a clear in one cycle: the edges must win
    p = 4'($urandom) | 4'h1;
    status = status ^ p;
    eclr = 4'hf;
    step(1);
    eclr = 4'h0;
    step(2);
    check(ev_lat, p);
    for (int k = 0; k < 16; k++) begin
      style = k[0];
      emask = k[3] ? 4'hf : 4'($urandom);
      host_u.write_byte(ADDR_GLOBAL_CONFIG, {k[1], 2'b11, k[2], 4'h0});
      step(2);
      check(irq, (!k[1] && |(p & ~emask)) ^ k[0] ^ k[2]);
    end
    style = 1'b0;
    $display("test interrupt done");
    // One-second strobe: enabled, disabled, blocked by soft reset
    for (int k = 0; k < 3; k++) begin
      host_u.write_byte(ADDR_GLOBAL_CONFIG, {4'h0, k != 1, 3'b000});
      if (k == 2) begin
        host_u.write_byte(ADDR_SOFTWARE_RESET_KEY, SOFT_RESET_KEY);
      end
      n = 0;
      pulse = 1'b1;
      repeat (10) begin
        step(1);
        n += int'(shadow);
      end
      pulse = 1'b0;
      step(6);
      check(16'(n), 16'(k == 0));
    end
    host_u.write_byte(ADDR_SOFTWARE_RESET_KEY, BYTE_ZERO);
    $display("test shadow done");
    // Highway decode over strap and the three legal codes
    for (int k = 0; k < 8; k++) begin
      if (k[1:0] == 2'b11) begin
        continue;
      end
      strap = k[2];
      host_u.write_byte(ADDR_GLOBAL_CONFIG, {5'h00, k[1:0], 1'b0});
      step(1);
      check(hwy, hwy_exp(3'(k)));
    end
    $display("test highway done");
    final_report();
  end
endmodule : test_quad_framer_global_regs
